// File: logic/asid_pkg.sv
// package for the serial audio input deframer: framings, widths, slot timing
// assumes both ends and the link checker import it; the interface does not
package asid_pkg;
  typedef enum logic [1:0] {
    ASID_FMT_I2S,
    ASID_FMT_LJ,
    ASID_FMT_RJ
  } asid_fmt_t;
  typedef enum logic [1:0] {
    ASID_W16,
    ASID_W18,
    ASID_W20,
    ASID_W24
  } asid_width_t;
  localparam int ASID_MAX_W = 24;
  localparam int ASID_SLOT_BITS = 32;
  localparam int ASID_CNT_W = 6;
  localparam int ASID_I2S_DELAY = 1;
  localparam int ASID_SYS_CLK_NS = 40;
  localparam int ASID_LINK_DIV = 4;
  localparam int ASID_DIV_W = 3;

  function automatic logic [4:0] asid_bits(input asid_width_t w);
    case (w)
      ASID_W16: asid_bits = 5'h10;
      ASID_W18: asid_bits = 5'h12;
      ASID_W20: asid_bits = 5'h14;
      default: asid_bits = 5'h18;
    endcase
  endfunction

  // bit slot (0 = first bit clock after word clock transition) of the msb
  function automatic logic [5:0] asid_msb_slot(input asid_fmt_t f, input asid_width_t w);
    case (f)
      ASID_FMT_I2S: asid_msb_slot = 6'(ASID_I2S_DELAY);
      ASID_FMT_RJ: asid_msb_slot = 6'(ASID_SLOT_BITS) - {1'b0, asid_bits(w)};
      default: asid_msb_slot = 6'h00;
    endcase
  endfunction

  // level of the word clock that marks the left channel
  function automatic logic asid_left_level(input asid_fmt_t f);
    asid_left_level = (f != ASID_FMT_I2S);
  endfunction
endpackage

// File: logic/asid_link_if.sv
// link between the audio source and the deframer: bit clock, word clock, data
// assumes both ends run on their own system clocks; the source makes the bit clock
`timescale 1ns/1ps
`default_nettype none
interface asid_link_if;
  logic bit_clk;
  logic word_clk;
  logic serial_sample_line;
  modport source (output bit_clk, output word_clk, output serial_sample_line);
  modport sink (input bit_clk, input word_clk, input serial_sample_line);
endinterface
`default_nettype wire

// File: logic/asid_deframer.sv
// serial audio input deframer: samples the link and emits tagged channel samples
// assumes the link pins are asynchronous to mclk_i and the bit clock is slow enough
// (at least 4 mclk_i periods per bit clock period) for edge detection
//
// Summary of operation
// - left-justified, I2S or right-justified framing selectable
// - word widths 16, 18, 20 or 24 selectable
// - right-justified: word clock high means left
// - data captured on rising bit clock edge
// - right-justified msb delay 12 (20-bit), 16 (16-bit)
// - 64 bit clocks per frame: lsb ends at transition
// - I2S is default; word clock low means left
// - I2S msb one bit clock after transition
// - left-justified: high is left, msb immediate
`timescale 1ns/1ps
`default_nettype none
module asid_deframer
  import asid_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  asid_link_if.sink link,
  input wire asid_fmt_t fmt_i,
  input wire asid_width_t width_i,
  output logic [ASID_MAX_W-1:0] sample_o,
  output logic left_o,
  output logic sample_valid_o
);
  logic [1:0] bclk_sync_q;
  logic [1:0] wclk_sync_q;
  logic [1:0] data_sync_q;
  logic bclk_last_q;
  logic wclk_last_q;
  logic seen_wclk_q;
  logic [ASID_CNT_W-1:0] slot_q;
  logic [ASID_MAX_W-1:0] shift_q;
  logic chan_left_q;
  logic [4:0] nbits;
  logic [5:0] msb_slot;
  logic rise;
  logic wclk_edge;
  logic [ASID_CNT_W-1:0] cur_slot;
  logic in_word;
  logic last_bit;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bclk_sync_q <= 2'h0;
      wclk_sync_q <= 2'h0;
      data_sync_q <= 2'h0;
    end
    else
    begin
      bclk_sync_q <= {bclk_sync_q[0], link.bit_clk};
      wclk_sync_q <= {wclk_sync_q[0], link.word_clk};
      data_sync_q <= {data_sync_q[0], link.serial_sample_line};
    end
  end

  // data and word clock are delayed as much as the bit clock, so they are
  // sampled at the synchronised rising edge with the source's setup intact
  assign rise = bclk_sync_q[1] & ~bclk_last_q;
  assign wclk_edge = wclk_sync_q[1] != wclk_last_q;
  assign nbits = asid_bits(width_i);
  assign msb_slot = asid_msb_slot(fmt_i, width_i);
  assign cur_slot = wclk_edge ? '0 : slot_q;
  assign in_word = seen_wclk_q && (cur_slot >= msb_slot)
    && (cur_slot < msb_slot + 6'(nbits));
  // right-justified: msb at 32 - n so the lsb lands on slot 31, the last
  // bit before the next transition when the frame holds 64 bit clocks
  assign last_bit = cur_slot == msb_slot + 6'(nbits) - 6'h01;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bclk_last_q <= 1'b0;
      wclk_last_q <= 1'b0;
      seen_wclk_q <= 1'b0;
      slot_q <= '0;
      chan_left_q <= 1'b0;
    end
    else
    begin
      bclk_last_q <= bclk_sync_q[1];
      if (rise)
      begin
        wclk_last_q <= wclk_sync_q[1];
        if (wclk_edge)
        begin
          seen_wclk_q <= 1'b1;
          // I2S left is low, the other framings left is high
          chan_left_q <= wclk_sync_q[1] == asid_left_level(fmt_i);
        end
        // saturate so a channel wider than 64 clocks does not wrap into a new word
        if (cur_slot != '1)
          slot_q <= cur_slot + 6'h01;
        else
          slot_q <= cur_slot;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      shift_q <= '0;
    else if (rise && in_word)
      shift_q <= {shift_q[ASID_MAX_W-2:0], data_sync_q[1]};
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sample_o <= '0;
      left_o <= 1'b0;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= 1'b0;
      if (rise && in_word && last_bit)
      begin
        // right-aligned at the chosen width, upper bits zero
        sample_o <= {shift_q[ASID_MAX_W-2:0], data_sync_q[1]}
          & ((24'h000001 << nbits) - 24'h000001);
        left_o <= wclk_edge ? (wclk_sync_q[1] == asid_left_level(fmt_i)) : chan_left_q;
        sample_valid_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/asid_source.sv
// audio source end: makes bit and word clocks by division, shifts out samples
// assumes user holds left/right samples; they are latched at each frame start
`timescale 1ns/1ps
`default_nettype none
module asid_source
  import asid_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  asid_link_if.source link,
  input wire asid_fmt_t fmt_i,
  input wire asid_width_t width_i,
  input wire logic [ASID_MAX_W-1:0] left_i,
  input wire logic [ASID_MAX_W-1:0] right_i,
  output logic frame_start_o
);
  logic [ASID_DIV_W-1:0] div_q;
  logic bclk_q;
  logic wclk_q;
  logic data_q;
  logic [ASID_CNT_W-1:0] slot_q;
  logic last_slot;
  logic nwclk;
  logic [5:0] nslot;
  logic [ASID_MAX_W-1:0] left_q;
  logic [ASID_MAX_W-1:0] right_q;
  logic [ASID_MAX_W-1:0] word;
  logic [5:0] msb_slot;
  logic [5:0] idx;
  logic fall;

  assign link.bit_clk = bclk_q;
  assign link.word_clk = wclk_q;
  assign link.serial_sample_line = data_q;
  // drive on the falling edge so the sink sees stable lines at the rise
  assign fall = (div_q == 3'(ASID_LINK_DIV - 1)) && bclk_q;
  assign msb_slot = asid_msb_slot(fmt_i, width_i);
  // 32 bit clocks per channel, so a frame is 64 bit clocks
  assign last_slot = slot_q == 6'(ASID_SLOT_BITS - 1);
  // lines set at this fall are sampled at the next rise, so compute for the next slot
  assign nslot = last_slot ? 6'h00 : slot_q + 6'h01;
  // word clock toggles on every wrap whatever the framing, so a framing change
  // never makes a short or long channel
  assign nwclk = last_slot ? ~wclk_q : wclk_q;
  // samples latched on this same edge are taken straight from the inputs
  assign word = (nwclk == asid_left_level(fmt_i)) ? (last_slot ? left_i : left_q)
    : right_q;
  assign idx = nslot - msb_slot;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
      bclk_q <= 1'b0;
    end
    else if (div_q == 3'(ASID_LINK_DIV - 1))
    begin
      div_q <= '0;
      bclk_q <= ~bclk_q;
    end
    else
      div_q <= div_q + 3'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      slot_q <= '0;
      wclk_q <= 1'b0;
      data_q <= 1'b0;
      left_q <= '0;
      right_q <= '0;
      frame_start_o <= 1'b0;
    end
    else
    begin
      frame_start_o <= 1'b0;
      if (fall)
      begin
        slot_q <= nslot;
        wclk_q <= nwclk;
        // a frame starts with the left channel
        if (last_slot && (nwclk == asid_left_level(fmt_i)))
        begin
          left_q <= left_i;
          right_q <= right_i;
          frame_start_o <= 1'b1;
        end
        if (nslot >= msb_slot && idx < 6'(asid_bits(width_i)))
          data_q <= word[5'(6'(asid_bits(width_i)) - 6'h01 - idx)];
        else
          data_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/asid_link_properties.sv
// wire and output checker for the serial audio link between source and deframer
// assumes the bit clock is made by the source from mclk_i, so no synchroniser here
`timescale 1ns/1ps
`default_nettype none
module asid_link_properties
  import asid_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic bit_clk,
  input wire logic word_clk,
  input wire logic serial_sample_line,
  input wire asid_fmt_t fmt_i,
  input wire logic sample_valid_o,
  input wire logic left_o
);
  logic [6:0] rise_cnt_q;
  logic seen_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || $changed(word_clk))
      rise_cnt_q <= 7'h00;
    else if ($rose(bit_clk))
      rise_cnt_q <= rise_cnt_q + 7'h01;
  end
  // first channel after reset may be short, so it is not measured
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      seen_q <= 1'b0;
    else if ($changed(word_clk))
      seen_q <= 1'b1;
  end
  rise_stable_a: assert property ($rose(bit_clk) |-> $stable(word_clk) &&
    $stable(serial_sample_line)) else $error("lines moved at bit clock rise");
  high_hold_a: assert property (bit_clk && $past(bit_clk) |->
    $stable(serial_sample_line)) else $error("data moved while bit clock high");
  word_low_a: assert property ($changed(word_clk) |-> !bit_clk)
    else $error("word clock moved while bit clock high");
  bclk_high_a: assert property ($rose(bit_clk) |=> bit_clk [*3] ##1 !bit_clk)
    else $error("bit clock high phase wrong");
  bclk_low_a: assert property ($fell(bit_clk) |=> !bit_clk [*3] ##1 bit_clk)
    else $error("bit clock low phase wrong");
  chan_len_a: assert property (seen_q && $changed(word_clk) |-> rise_cnt_q == 7'h20)
    else $error("channel length not 32 bit clocks");
  valid_pulse_a: assert property (sample_valid_o |=> !sample_valid_o)
    else $error("sample valid longer than one cycle");
  tag_level_a: assert property (sample_valid_o |->
    left_o == ((fmt_i == ASID_FMT_I2S) ? !word_clk : word_clk)) else $error("bad channel tag");
  cover property (sample_valid_o && left_o);
  cover property (sample_valid_o && !left_o);
  cover property (seen_q && $changed(word_clk));
endmodule
`default_nettype wire

// File: tb/test_audio_serial_input_deframer.sv
// bench joining source and deframer over the link, checking samples and tags
// assumes both ends share mclk_i; formats change right after a frame start
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module test_audio_serial_input_deframer
  import asid_pkg::*;
;
  typedef struct packed {asid_width_t w; logic [23:0] l; logic [23:0] r;} asid_row_t;
  asid_row_t rows [4] = '{'{ASID_W16, 24'h00A5C3, 24'h005A3C}, '{ASID_W18, 24'h02B4E1,
    24'h01C3D2}, '{ASID_W20, 24'h0F0E1D, 24'h0A5A5A}, '{ASID_W24, 24'hC35A81, 24'h3CA57E}};
  logic mclk_i;
  logic rst_i = 1'b1;
  asid_fmt_t fmt_i = ASID_FMT_I2S;
  asid_width_t width_i = ASID_W24;
  logic [23:0] left_i = 24'h000000;
  logic [23:0] right_i = 24'h000000;
  logic frame_start_o;
  logic [23:0] sample_o;
  logic left_o;
  logic sample_valid_o;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  asid_link_if link();
  asid_source i_asid_source (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .fmt_i(fmt_i),
    .width_i(width_i), .left_i(left_i), .right_i(right_i), .frame_start_o(frame_start_o));
  asid_deframer i_asid_deframer (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .fmt_i(fmt_i),
    .width_i(width_i), .sample_o(sample_o), .left_o(left_o), .sample_valid_o(sample_valid_o));
  asid_link_properties i_asid_link_properties (.mclk_i(mclk_i), .rst_i(rst_i),
    .bit_clk(link.bit_clk), .word_clk(link.word_clk),
    .serial_sample_line(link.serial_sample_line), .fmt_i(fmt_i),
    .sample_valid_o(sample_valid_o), .left_o(left_o));
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // which 0 waits for a frame start, 1 for a sample; a frame is 512 cycles
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end
    while (((which == 0) ? frame_start_o : sample_valid_o) !== 1'b1 && n < 3000);
    if (n >= 3000)
      failures++;
  endtask
  task automatic check_pair(input asid_row_t r);
    logic [1:0] seen;
    seen = 2'h0;
    repeat (2)
    begin
      wait_for(1);
      seen = seen | (left_o ? 2'h2 : 2'h1);
      `CHK(sample_o, left_o ? r.l : r.r) // value by channel
    end
    `CHK(seen, 2'h3) // both channels tagged
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    for (int f = 0; f < 3; f++)
      for (int k = 0; k < 4; k++)
      begin
        wait_for(0);
        fmt_i = asid_fmt_t'(f); // every framing
        width_i = rows[k].w; // every width
        left_i = rows[k].l;
        right_i = rows[k].r;
        wait_for(0);
        check_pair(rows[k]);
        $display("test fmt %0d width %0d done", f, k);
      end
    wait_for(1);
    repeat (3) @(negedge mclk_i);
    rst_i = 1'b1;
    fmt_i = ASID_FMT_I2S;
    width_i = rows[1].w;
    left_i = rows[1].l;
    right_i = rows[1].r;
    @(negedge mclk_i);
    `CHK({sample_valid_o, left_o, sample_o}, 26'h0000000) // outputs cleared
    rst_i = 1'b0;
    wait_for(0);
    wait_for(0);
    check_pair(rows[1]); // default framing after reset
    $display("test reset in mid frame done");
    print_verdict();
  end
endmodule
`default_nettype wire
